// ---- hw/spcp_clkgen.sv ----
// Master-mode configuration clock divider with rising-edge enable
module spcp_clkgen
    import spcp_pkg::*;
#(
    parameter int HALF_PERIOD = CFG_HALF_PERIOD_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_run,
    output logic      o_clk,
    output logic      o_rise
);
    localparam longint F_ACT = SYS_CLK_HZ / (2 * HALF_PERIOD);
    localparam longint F_NOM = CFG_CLK_NOMINAL_HZ;

    // Generated rate must sit inside the allowed deviation
    if (HALF_PERIOD < 1 ||
        F_ACT * 100 > F_NOM * (100 + FREQ_TOL_UP_PCT) ||
        F_ACT * 100 < F_NOM * (100 - FREQ_TOL_DN_PCT)) begin : g_chk
        $error("spcp_clkgen: HALF_PERIOD out of range");
    end

    logic [15:0] cnt_q;

    always_ff @(posedge i_clk) begin
        if (i_srst || !i_run) begin
            cnt_q  <= '0;
            o_clk  <= 1'b0;
            o_rise <= 1'b0;
        end else if (cnt_q == 16'(HALF_PERIOD - 1)) begin
            cnt_q  <= '0;
            o_clk  <= ~o_clk;
            o_rise <= ~o_clk;
        end else begin
            cnt_q  <= cnt_q + 16'h1;
            o_rise <= 1'b0;
        end
    end
endmodule // spcp_clkgen

// ---- hw/spcp_sync.sv ----
// Two-flop synchroniser for a bundle of pin inputs
module spcp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // spcp_sync

// ---- hw/spcp_top.sv ----
// Serial and 8-bit parallel configuration data port
// What this block does
// (RULE1) One serial bit taken per config clock
// (RULE2) Loader sends each byte MSB first
// (RULE3) Slave serial clock comes from outside
// (RULE4) Serial output quiet until own stream done
// (RULE5) CRC covers only this device's own data
// (RULE6) Downstream data forwarded after eighty cycles
// (RULE7) Each chained bitstream has own sync word
// (RULE8) Own bitstream never appears on serial output
// (RULE9) Completion release no later than tristate release
// (RULE10) Active completion drive only on last device
// (RULE11) Master clock within +45%/-30% of nominal
// (RULE12) Eight-bit two-way bus for load and readback
// (RULE13) Parallel devices share lines, own chip select
// (RULE14) Tied selects only for identical simple loads
// (RULE15) Bus line D0 carries byte MSB
// (RULE16) Read/write low writes, high reads
// (RULE17) Bus used only while chip select low
// (RULE18) Master parallel drives config clock out
// (RULE19) One byte per rising edge, busy handshake
// (RULE20) Inactive until init-ready high, then load
// (RULE21) Read/write rising mid-load aborts configuration
// (RULE22) After abort only program reset recovers
// (RULE23) Byte seen while busy is ignored
// (RULE24) No-handshake limit is 66 MHz
// (RULE25) Program reset returns loaders to idle
// (RULE26) Serial bits packed into bytes MSB first
module spcp_top
    import spcp_pkg::*;
#(
    parameter int FWD_LAT  = FWD_LATENCY,
    parameter int HALF_PER = CFG_HALF_PERIOD_CYC
) (
    input  wire logic       I_CLK,
    input  wire logic       I_SRST,
    input  wire logic [2:0] I_MODE,
    input  wire logic       I_CONFIG_CLOCK,
    output logic            O_CONFIG_CLOCK,
    output logic            O_CONFIG_CLOCK_OE,
    input  wire logic       I_SERIAL_DIN,
    output logic            O_SERIAL_DOUT,
    input  wire logic       I_PROGRAM_RESET_N,
    input  wire logic       I_INIT_READY,
    input  wire logic       I_CHIP_SELECT_N,
    input  wire logic       I_READ_WRITE_N,
    input  wire logic [7:0] I_DATA,
    output logic      [7:0] O_DATA,
    output logic            O_DATA_OE,
    output logic            O_BUSY,
    output logic            O_BUSY_OE,
    input  wire logic       I_COMPLETION,
    output logic            O_COMPLETION,
    output logic            O_COMPLETION_OE,
    input  wire logic       I_COMPLETION_ACTIVE_DRIVE,
    input  wire logic       I_CORE_BUSY,
    input  wire logic       I_STREAM_COMPLETE,
    input  wire logic [7:0] I_READBACK_BYTE,
    output spcp_byte_s      O_CFG_BYTE,
    output logic            O_READBACK_TAKEN,
    output logic            O_OWN_STREAM,
    output logic            O_ABORTED,
    output logic            O_GLOBAL_TRISTATE_RELEASE
);

    // Delay line needs a real tail and head
    if (FWD_LAT < 2) begin : g_chk
        $error("spcp_top: FWD_LAT must be at least 2");
    end
    if (COMPLETION_PHASE > GTS_PHASE) begin : g_phase_chk
        $error("spcp_top: completion phase after tristate release");
    end

    spcp_pins_s pins_raw;
    spcp_pins_s pins;
    spcp_ser_e  ser_q;
    spcp_par_e  par_q;

    logic       config_clock_prev_q;
    logic       ext_rise;
    logic       gen_clk;
    logic       gen_rise;
    logic       rise;
    logic       is_master;
    logic       is_serial;
    logic       is_parallel;
    logic       prog_active;
    logic       selected;
    logic       ser_fire;
    logic       par_take;
    logic       par_read;
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic [7:0] ser_byte;
    logic [2:0] phase_q;
    logic       started_q;
    logic       released;

    logic [FWD_LAT-1:0] fwd_bit_q;
    logic [FWD_LAT-1:0] fwd_vld_q;

    // All pins cross into I_CLK through two flops
    always_comb begin
        pins_raw.mode       = I_MODE;
        pins_raw.config_clock       = I_CONFIG_CLOCK;    // (RULE3)
        pins_raw.din        = I_SERIAL_DIN;
        pins_raw.prog_n     = I_PROGRAM_RESET_N;
        pins_raw.init       = I_INIT_READY;
        pins_raw.cs_n       = I_CHIP_SELECT_N;
        pins_raw.rdwr_n     = I_READ_WRITE_N;
        pins_raw.completion = I_COMPLETION;
        pins_raw.data       = I_DATA;
    end

    spcp_sync #(
        .W ($bits(spcp_pins_s))
    ) u_sync (
        .i_clk   (I_CLK),
        .i_srst  (I_SRST),
        .i_async (pins_raw),
        .o_sync  (pins)
    );

    assign is_master   = (pins.mode == MODE_MASTER_SERIAL) ||
                         (pins.mode == MODE_MASTER_PARALLEL);
    assign is_serial   = (pins.mode == MODE_MASTER_SERIAL) ||
                         (pins.mode == MODE_SLAVE_SERIAL);
    assign is_parallel = (pins.mode == MODE_MASTER_PARALLEL) ||
                         (pins.mode == MODE_SLAVE_PARALLEL);
    assign prog_active = ~pins.prog_n;
    assign selected    = is_parallel & ~pins.cs_n;

    // External clock edge found from the synchronised level
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            config_clock_prev_q <= 1'b0;
        end else begin
            config_clock_prev_q <= pins.config_clock;
        end
    end

    assign ext_rise = pins.config_clock & ~config_clock_prev_q;

    // Master clock held still until init-ready, as the loader expects
    spcp_clkgen #(
        .HALF_PERIOD (HALF_PER)
    ) u_clkgen (
        .i_clk  (I_CLK),
        .i_srst (I_SRST),
        .i_run  (is_master & pins.init & ~prog_active),    // (RULE11)
        .o_clk  (gen_clk),
        .o_rise (gen_rise)
    );

    assign O_CONFIG_CLOCK    = gen_clk;
    assign O_CONFIG_CLOCK_OE = is_master;    // (RULE18)
    assign rise              = is_master ? gen_rise : ext_rise;

    // Serial loader
    always_ff @(posedge I_CLK) begin
        if (I_SRST || prog_active) begin    // (RULE25)
            ser_q <= SER_IDLE;
        end else begin
            unique case (ser_q)
                SER_IDLE: begin
                    if (is_serial && pins.init) begin
                        ser_q <= SER_OWN;
                    end
                end
                SER_OWN: begin
                    if (I_STREAM_COMPLETE) begin
                        ser_q <= SER_FORWARD;    // (RULE4)
                    end
                end
                SER_FORWARD: begin
                    ser_q <= SER_FORWARD;
                end
                default: begin
                    ser_q <= SER_IDLE;
                end
            endcase
        end
    end

    // Partial byte is dropped at the own/forward boundary
    always_ff @(posedge I_CLK) begin
        if (I_SRST || prog_active || ser_q != SER_OWN ||
            I_STREAM_COMPLETE) begin    // (RULE25)
            bit_cnt_q <= '0;
            shift_q   <= '0;
        end else if (rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;    // (RULE1)
            shift_q   <= {shift_q[5:0], pins.din};    // (RULE2)
        end
    end

    assign ser_fire = (ser_q == SER_OWN) & rise & ~I_STREAM_COMPLETE &
                      (bit_cnt_q == 3'h7);
    assign ser_byte = {shift_q, pins.din};    // (RULE26)

    // Forward bits tagged valid only after own stream, so none of it leaks
    always_ff @(posedge I_CLK) begin
        if (I_SRST || prog_active) begin    // (RULE25)
            fwd_bit_q <= '0;
            fwd_vld_q <= '0;
        end else if (rise) begin
            fwd_bit_q <= {fwd_bit_q[FWD_LAT-2:0], pins.din};    // (RULE7)
            fwd_vld_q <= {fwd_vld_q[FWD_LAT-2:0],
                          ser_q == SER_FORWARD};    // (RULE8)
        end
    end

    // Bit enters at one edge and leaves FWD_LAT edges later
    always_ff @(posedge I_CLK) begin
        if (I_SRST || prog_active) begin
            O_SERIAL_DOUT <= SERIAL_IDLE_LEVEL;
        end else if (rise) begin
            O_SERIAL_DOUT <= fwd_vld_q[FWD_LAT-1] ?
                             fwd_bit_q[FWD_LAT-1] :
                             SERIAL_IDLE_LEVEL;    // (RULE6)
        end
    end

    // Parallel loader
    always_ff @(posedge I_CLK) begin
        if (I_SRST || prog_active) begin    // (RULE22)
            par_q <= PAR_IDLE;
        end else begin
            unique case (par_q)
                PAR_IDLE: begin
                    if (is_parallel && pins.init) begin
                        par_q <= PAR_LOAD;    // (RULE20)
                    end
                end
                PAR_LOAD: begin
                    if (I_STREAM_COMPLETE) begin
                        par_q <= PAR_READ;
                    end else if (rise && selected && pins.rdwr_n) begin
                        par_q <= PAR_ABORT;    // (RULE21)
                    end
                end
                PAR_ABORT: begin
                    par_q <= PAR_ABORT;    // (RULE22)
                end
                PAR_READ: begin
                    par_q <= PAR_READ;
                end
            endcase
        end
    end

    // Chip select and write level both sampled at the edge
    assign par_take = (par_q == PAR_LOAD) & rise & selected &
                      ~pins.rdwr_n & ~I_CORE_BUSY &
                      ~I_STREAM_COMPLETE;    // (RULE19) (RULE23)
    assign par_read = (par_q == PAR_READ) & rise & selected &
                      pins.rdwr_n;    // (RULE16)

    // One byte path into the packet processor for both loaders
    always_ff @(posedge I_CLK) begin
        if (I_SRST || prog_active) begin
            O_CFG_BYTE <= '0;
        end else if (ser_fire) begin
            O_CFG_BYTE <= '{valid: 1'b1, data: ser_byte};    // (RULE5)
        end else if (par_take) begin
            O_CFG_BYTE <= '{valid: 1'b1,
                            data: spcp_swap(pins.data)};    // (RULE15)
        end else begin
            O_CFG_BYTE.valid <= 1'b0;
        end
    end

    // Readback byte held on the bus until the next read edge
    always_ff @(posedge I_CLK) begin
        if (I_SRST || prog_active) begin
            O_DATA           <= '0;
            O_READBACK_TAKEN <= 1'b0;
        end else begin
            O_READBACK_TAKEN <= par_read;
            if (par_read) begin
                O_DATA <= spcp_swap(I_READBACK_BYTE);    // (RULE15)
            end
        end
    end

    // Drive the bus only when selected and reading
    assign O_DATA_OE = selected & pins.rdwr_n &
                       (par_q == PAR_READ);    // (RULE12) (RULE17)
    // Busy floats when deselected; loader rate above 66 MHz needs it
    assign O_BUSY    = I_CORE_BUSY;    // (RULE19)
    assign O_BUSY_OE = selected;    // (RULE17)

    assign O_OWN_STREAM = (ser_q == SER_OWN) ||
                          (par_q == PAR_LOAD);    // (RULE5)
    assign O_ABORTED    = (par_q == PAR_ABORT);

    // Start-up sequencer after a clean, complete own stream
    always_ff @(posedge I_CLK) begin
        if (I_SRST || prog_active) begin
            started_q <= 1'b0;
            phase_q   <= '0;
        end else begin
            if (I_STREAM_COMPLETE && par_q != PAR_ABORT) begin
                started_q <= 1'b1;
            end
            if (started_q && rise && phase_q != LAST_PHASE) begin
                phase_q <= phase_q + 3'h1;
            end
        end
    end

    assign released = started_q && phase_q >= COMPLETION_PHASE;

    // Open drain low until released; active high drive is optional
    assign O_COMPLETION    = released;
    assign O_COMPLETION_OE = ~released |
                             I_COMPLETION_ACTIVE_DRIVE;    // (RULE10)

    // Tristate release waits for the shared completion line
    always_ff @(posedge I_CLK) begin
        if (I_SRST || prog_active) begin
            O_GLOBAL_TRISTATE_RELEASE <= 1'b0;
        end else if (released && phase_q >= GTS_PHASE &&
                     pins.completion) begin
            O_GLOBAL_TRISTATE_RELEASE <= 1'b1;    // (RULE9)
        end
    end

endmodule // spcp_top

// ---- include/spcp_pkg.sv ----
// Shared constants and types of the serial/parallel configuration port
package spcp_pkg;

    // Mode pin codes (mode[2:0])
    localparam logic [2:0] MODE_MASTER_SERIAL   = 3'h0;
    localparam logic [2:0] MODE_SLAVE_SERIAL    = 3'h7;
    localparam logic [2:0] MODE_MASTER_PARALLEL = 3'h3;
    localparam logic [2:0] MODE_SLAVE_PARALLEL  = 3'h6;

    // Clocking
    localparam int SYS_CLK_HZ            = 100_000_000;
    localparam int CFG_CLK_NOMINAL_HZ    = 12_500_000;
    localparam int FREQ_TOL_UP_PCT       = 45;
    localparam int FREQ_TOL_DN_PCT       = 30;
    localparam int PARALLEL_MAX_RATE_MHZ = 66;
    localparam int CFG_HALF_PERIOD_CYC   =
        SYS_CLK_HZ / (2 * CFG_CLK_NOMINAL_HZ);

    // Daisy-chain forwarding delay in config clock cycles
    localparam int FWD_LATENCY = 80;

    // Start-up sequencer phases
    localparam logic [2:0] COMPLETION_PHASE = 3'h4;
    localparam logic [2:0] GTS_PHASE        = 3'h5;
    localparam logic [2:0] LAST_PHASE       = 3'h7;

    // Serial output level while nothing is forwarded
    localparam logic SERIAL_IDLE_LEVEL = 1'b1;

    typedef enum logic [1:0] {
        SER_IDLE    = 2'b00,
        SER_OWN     = 2'b01,
        SER_FORWARD = 2'b10
    } spcp_ser_e;

    typedef enum logic [1:0] {
        PAR_IDLE  = 2'b00,
        PAR_LOAD  = 2'b01,
        PAR_ABORT = 2'b10,
        PAR_READ  = 2'b11
    } spcp_par_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } spcp_byte_s;

    typedef struct packed {
        logic [2:0] mode;
        logic       config_clock;
        logic       din;
        logic       prog_n;
        logic       init;
        logic       cs_n;
        logic       rdwr_n;
        logic       completion;
        logic [7:0] data;
    } spcp_pins_s;

    // Bus line 0 is the byte's MSB
    function automatic logic [7:0] spcp_swap(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

endpackage

// ---- verification/spcp_loader_model.sv ----
// Serial loader model driving the slave serial pins
module spcp_loader_model (
    output logic o_config_clock,
    output logic o_din
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_config_clock = 1'b0;
        o_din  = 1'b0;
    end
    // Clock stands low between frames; data parks inverted
    task automatic send(input int n, input logic [7:0] v);
        #3;
        for (int i = 7; i > 7 - n; i--) begin
            o_din = v[i];
            #62.5 o_config_clock = 1'b1;
            #62.5 o_config_clock = 1'b0;
        end
        #31.25 o_din = ~o_din;
    endtask
endmodule // spcp_loader_model

// ---- verification/spcp_properties.sv ----
// Concurrent checks on the configuration port top
module spcp_properties
    import spcp_pkg::*;
(
    input wire logic       I_CLK,
    input wire logic       I_SRST,
    input wire logic [2:0] I_MODE,
    input wire logic       I_STREAM_COMPLETE,
    input wire logic       I_CORE_BUSY,
    input wire logic       I_PROGRAM_RESET_N,
    input wire logic       I_CHIP_SELECT_N,
    input wire logic       O_SERIAL_DOUT,
    input wire logic       O_BUSY,
    input wire logic       O_BUSY_OE,
    input wire logic       O_DATA_OE,
    input wire logic       O_CONFIG_CLOCK_OE,
    input wire logic       O_COMPLETION,
    input wire logic       O_COMPLETION_OE,
    input wire logic       O_ABORTED,
    input wire logic       O_GLOBAL_TRISTATE_RELEASE,
    input wire spcp_byte_s O_CFG_BYTE
);
    // Set once forwarding may start; only a full reset clears it
    logic fwd_seen_q;
    always_ff @(posedge I_CLK) begin
        if (I_SRST) fwd_seen_q <= 1'b0;
        else if (I_STREAM_COMPLETE) fwd_seen_q <= 1'b1;
    end
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    a_dout_quiet: assert property (!fwd_seen_q |-> O_SERIAL_DOUT)
        else $error("serial output active before own stream done");
    a_slave_clk_in: assert property (
        (I_MODE == MODE_SLAVE_SERIAL)[*4] |-> !O_CONFIG_CLOCK_OE)
        else $error("config clock driven in slave serial mode");
    a_master_clk_out: assert property (
        (I_MODE == MODE_MASTER_PARALLEL)[*4] |-> O_CONFIG_CLOCK_OE)
        else $error("config clock not driven in master parallel mode");
    a_byte_single: assert property (
        O_CFG_BYTE.valid |=> !O_CFG_BYTE.valid)
        else $error("byte valid longer than one cycle");
    a_abort_blocks: assert property (O_ABORTED |-> !O_CFG_BYTE.valid)
        else $error("byte delivered while aborted");
    a_abort_sticky: assert property (
        I_PROGRAM_RESET_N[*3] ##0 O_ABORTED |=> O_ABORTED)
        else $error("abort cleared without program reset");
    a_deselect_quiet: assert property (
        I_CHIP_SELECT_N[*4] |-> !O_DATA_OE && !O_BUSY_OE)
        else $error("bus used while deselected");
    a_busy_core: assert property (O_BUSY == I_CORE_BUSY)
        else $error("busy does not follow core");
    a_gts_order: assert property (
        O_GLOBAL_TRISTATE_RELEASE |-> O_COMPLETION)
        else $error("tristate released before completion");
    a_done_low: assert property (!O_COMPLETION |-> O_COMPLETION_OE)
        else $error("completion line not held low");
endmodule // spcp_properties

// ---- verification/tb_top.sv ----
// Self-checking testbench for the configuration port
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import spcp_pkg::*;
    logic       clk, srst, prog_n, init, cs_n, rdwr_n, core_busy, strm;
    logic [2:0] mode;
    logic [7:0] bus_d, rb_byte, o_data;
    wire        config_clock_pin, ldr_clk, ldr_din, config_clock_o, config_clock_oe, dout, busy;
    wire        done_o, done_oe, done_pin, data_oe, rb_taken, own, abrt;
    wire        global_tristate_release, busy_oe;
    spcp_byte_s cfg_byte;
    logic [7:0] got_q[$], exp_q[$];
    int         miscompares, n_checks, k, gap;

    spcp_top #(.FWD_LAT(4)) uut (
        .I_CLK(clk), .I_SRST(srst), .I_MODE(mode),
        .I_CONFIG_CLOCK(config_clock_pin), .O_CONFIG_CLOCK(config_clock_o),
        .O_CONFIG_CLOCK_OE(config_clock_oe), .I_SERIAL_DIN(ldr_din),
        .O_SERIAL_DOUT(dout), .I_PROGRAM_RESET_N(prog_n),
        .I_INIT_READY(init), .I_CHIP_SELECT_N(cs_n),
        .I_READ_WRITE_N(rdwr_n), .I_DATA(bus_d), .O_DATA(o_data),
        .O_DATA_OE(data_oe), .O_BUSY(busy), .O_BUSY_OE(busy_oe),
        .I_COMPLETION(done_pin), .O_COMPLETION(done_o),
        .O_COMPLETION_OE(done_oe), .I_COMPLETION_ACTIVE_DRIVE(1'b0),
        .I_CORE_BUSY(core_busy), .I_STREAM_COMPLETE(strm),
        .I_READBACK_BYTE(rb_byte), .O_CFG_BYTE(cfg_byte),
        .O_READBACK_TAKEN(rb_taken), .O_OWN_STREAM(own),
        .O_ABORTED(abrt), .O_GLOBAL_TRISTATE_RELEASE(global_tristate_release)
    );
    spcp_loader_model ldr (.o_config_clock(ldr_clk), .o_din(ldr_din));
    assign config_clock_pin = config_clock_oe ? config_clock_o : ldr_clk;
    // Shared completion line has a pull-up
    assign done_pin = !(done_oe && !done_o);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cfg_byte.valid === 1'b1) got_q.push_back(cfg_byte.data);
    end

    function automatic logic [7:0] rev8(input logic [7:0] v);
        return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic hang();
        miscompares++;
        final_report();
    endtask
    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    // Returns just after the edge that shows a config clock rise
    task automatic wait_rise();
        logic p;
        p = 1'b1;
        for (gap = 0; gap < 40; gap++) begin
            @(posedge clk);
            if (config_clock_o === 1'b1 && !p) break;
            p = config_clock_o;
        end
        if (gap == 40) hang();
    endtask
    task automatic par_step(input logic [7:0] d, input logic b);
        wait_rise();
        cs_n      <= 1'b0;
        bus_d     <= rev8(d);
        core_busy <= b;
        if (!b) exp_q.push_back(d);
    endtask

    initial begin
        mode = MODE_SLAVE_SERIAL; srst = 1'b1; prog_n = 1'b1;
        init = 1'b1; cs_n = 1'b1; rdwr_n = 1'b0; core_busy = 1'b0;
        strm = 1'b0; bus_d = 8'hff; rb_byte = 8'h96;
        miscompares = 0; n_checks = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        exp_q.push_back(8'ha5);
        ldr.send(8, 8'ha5);
        @(posedge clk);
        chk1("own_stream", 1'b1, own);
        strm <= 1'b1;
        repeat (3) @(posedge clk);
        chk1("own_stream", 1'b0, own);
        ldr.send(4, 8'h00);
        @(posedge clk);
        chk1("dout", 1'b1, dout);
        ldr.send(4, 8'hf0);
        @(posedge clk);
        chk1("dout", 1'b0, dout);
        ldr.send(4, 8'hf0);
        @(posedge clk);
        chk1("dout", 1'b1, dout);
        // Select and read held while init-ready is low
        mode <= MODE_MASTER_PARALLEL; init <= 1'b0; strm <= 1'b0;
        srst <= 1'b1; cs_n <= 1'b0; rdwr_n <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (60) @(posedge clk);
        chk1("aborted", 1'b0, abrt);
        cs_n <= 1'b1; rdwr_n <= 1'b0; init <= 1'b1;
        par_step(8'h01, 1'b0);
        par_step(8'hb4, 1'b1);
        par_step(8'hb4, 1'b0);
        par_step(8'h7e, 1'b0);
        chk1("busy_oe", 1'b1, busy_oe);
        chk1("period", 1'b1, gap >= 5 && gap <= 10);
        wait_rise();
        rdwr_n <= 1'b1; bus_d <= 8'h33;
        wait_rise();
        rdwr_n <= 1'b0;
        wait_rise();
        wait_rise();
        chk1("aborted", 1'b1, abrt);
        cs_n <= 1'b1; prog_n <= 1'b0;
        repeat (4) @(posedge clk);
        prog_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk1("aborted", 1'b0, abrt);
        par_step(8'h5a, 1'b0);
        wait_rise();
        strm <= 1'b1; rdwr_n <= 1'b1;
        for (k = 0; k < 50 && rb_taken !== 1'b1; k++) @(posedge clk);
        if (k == 50) hang();
        chk8("readback", rev8(8'h96), o_data);
        chk1("data_oe", 1'b1, data_oe);
        for (k = 0; k < 200 && global_tristate_release !== 1'b1; k++) @(posedge clk);
        if (k == 200) hang();
        chk1("completion", 1'b1, done_o);
        chk1("completion_oe", 1'b0, done_oe);
        cs_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk1("data_oe", 1'b0, data_oe);
        chk8("byte_count", 8'(exp_q.size()), 8'(got_q.size()));
        foreach (exp_q[i]) begin
            if (i < got_q.size()) chk8("cfg_byte", exp_q[i], got_q[i]);
        end
        final_report();
    end
endmodule // tb_top

bind spcp_top spcp_properties chk (
    .I_CLK, .I_SRST, .I_MODE, .I_STREAM_COMPLETE, .I_CORE_BUSY,
    .I_PROGRAM_RESET_N, .I_CHIP_SELECT_N, .O_SERIAL_DOUT, .O_BUSY,
    .O_BUSY_OE, .O_DATA_OE, .O_CONFIG_CLOCK_OE, .O_COMPLETION,
    .O_COMPLETION_OE, .O_ABORTED, .O_GLOBAL_TRISTATE_RELEASE, .O_CFG_BYTE
);
